// *** design/csss_clock_switch.sv ***
// Clock source selection, glitch-free switching and clock-output pin control.
// Assumes software bits arrive on sys_clk; clock_input_pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "csss_regs.svh"

// Notes on behaviour
// - bus_clock_times_two runs at half of bus_clock_times_four.
// - The bus clock runs at a quarter of the active source clock.
// - Internal oscillator offers 12.8, 8.0 or 4.0 MHz for 3.2, 2.0, 1.0 MHz buses.
// - Reset selects the internal oscillator at its lowest rate.
// - The trim value is 8 bits, signed, from +127 down to -128.
// - A larger trim lengthens the internal period; a smaller one shortens it.
// - External source enables the input pin; crystal also drives the output pin.
// - Two external rising edges prove activity before the switch.
// - Switch is glitch-free; engaged status sets before the internal oscillator stops.
// - Direct mode uses the input pin as times-four and halves it for times-two.
// - Direct mode forces the clock-output enable off.
// - Crystal mode reserves the output pin and ignores the clock-output enable.
// - RC mode outputs the clock only when the clock-output enable is set.
// - No interrupts and no break-affected status flags.
// - The block runs normally in wait mode.
// - In stop mode it runs only when run_in_stop_enable is set.
// - Internal mode releases the input pin to other functions once engaged status clears.
// - Internal mode outputs times-four on the pin when clock-output is enabled.
// - Source codes: 00 internal, 01 direct, 10 RC, 11 crystal.
// - Rate codes: 00 4.0 MHz, 01 8.0 MHz, 10 12.8 MHz, 11 reserved.
// - Range codes enable one of three amplifiers; 11 enables none.
// - Reset clears the enable; engaged status reads 1 while external drives.
module csss_clock_switch #(
    parameter int ACC_WIDTH = `CSSS_ACC_WIDTH
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire csss_pkg::csss_source_type clock_source_select,
    input wire csss_pkg::csss_xtal_range_type crystal_range_select,
    input wire csss_pkg::csss_freq_type internal_freq_select,
    input wire logic external_clock_enable,
    input wire logic [7:0] internal_osc_trim,
    input wire logic clkout_pin_enable,
    input wire logic run_in_stop_enable,
    input wire logic stop_mode,
    input wire logic clock_input_pin,
    output logic bus_clock_times_four,
    output logic bus_clock_times_two,
    output logic bus_clock,
    output logic external_clock_engaged,
    output logic internal_osc_enable,
    output logic clock_input_pin_select,
    output logic [2:0] crystal_amp_enable,
    output logic clock_output_pin_out,
    output logic clock_output_pin_oe,
    output logic clkout_pin_enable_effective
);
    import csss_pkg::*;

    localparam logic [1:0] EDGES_NEEDED = 2'(`CSSS_ACTIVITY_EDGES);

    if (`CSSS_ACTIVITY_EDGES < 1 || `CSSS_ACTIVITY_EDGES > 3) begin : g_bad_edges
        $error("csss_clock_switch: activity edge count must lie between 1 and 3");
    end

    typedef struct packed {
        logic pin_first;
        logic pin_second;
        logic pin_prev;
        csss_switch_type phase;
        logic [1:0] edge_count;
        logic osc_run;
        logic engaged;
        logic times_four;
        logic times_two;
        logic bus;
        logic input_select;
        logic [2:0] amp;
        logic pin_out;
        logic pin_oe;
        logic clkout_effective;
    } csss_switch_state_type;

    csss_switch_state_type state;
    csss_switch_state_type next_state;
    csss_osc_if osc_link();

    logic active;
    logic want_external;
    logic want_internal;
    logic ext_rise;
    logic source_level;
    logic both_low;

    csss_internal_osc #(
        .ACC_WIDTH(ACC_WIDTH)
    ) u_internal_osc (
        .sys_clk(sys_clk),
        .reset(reset),
        .link(osc_link)
    );

    // The trim is passed through as written; the factory value is never fetched.
    assign osc_link.trim = internal_osc_trim;
    assign osc_link.freq_select = internal_freq_select;
    assign osc_link.run = state.osc_run;

    always_comb begin
        next_state = state;

        // Wait mode has no input here: only stop mode halts the block.
        active = !(stop_mode && !run_in_stop_enable);

        // Software has already waited for the source to settle before enabling.
        want_external = external_clock_enable && (clock_source_select != CSSS_SRC_INTERNAL);
        want_internal = !external_clock_enable && (clock_source_select == CSSS_SRC_INTERNAL);

        next_state.pin_first = clock_input_pin;
        next_state.pin_second = state.pin_first;
        next_state.pin_prev = state.pin_second;
        ext_rise = active && state.pin_second && !state.pin_prev;
        // Handover only while both clocks sit low, so no short pulse escapes.
        both_low = !state.pin_second && !osc_link.clock_level;

        unique case (state.phase)
            CSSS_SW_INT_RUN: begin
                next_state.edge_count = 2'h0;
                next_state.osc_run = active;
                if (want_external && active) begin
                    next_state.phase = CSSS_SW_EXT_CHECK;
                end
            end
            CSSS_SW_EXT_CHECK: begin
                next_state.osc_run = active;
                if (!want_external) begin
                    next_state.phase = CSSS_SW_INT_RUN;
                end else if (ext_rise) begin
                    next_state.edge_count = state.edge_count + 2'h1;
                    if (state.edge_count + 2'h1 == EDGES_NEEDED) begin
                        next_state.phase = CSSS_SW_EXT_HANDOVER;
                    end
                end
            end
            CSSS_SW_EXT_HANDOVER: begin
                next_state.osc_run = active;
                if (!want_external) begin
                    next_state.phase = CSSS_SW_INT_RUN;
                end else if (both_low) begin
                    // Status rises here; the oscillator stops one edge later.
                    next_state.engaged = 1'b1;
                    next_state.phase = CSSS_SW_EXT_RUN;
                end
            end
            CSSS_SW_EXT_RUN: begin
                next_state.osc_run = 1'b0;
                if (want_internal) begin
                    next_state.osc_run = active;
                    next_state.phase = CSSS_SW_INT_HANDOVER;
                end
            end
            CSSS_SW_INT_HANDOVER: begin
                next_state.osc_run = active;
                if (!want_internal) begin
                    next_state.osc_run = 1'b0;
                    next_state.phase = CSSS_SW_EXT_RUN;
                end else if (both_low && state.osc_run) begin
                    next_state.engaged = 1'b0;
                    next_state.edge_count = 2'h0;
                    next_state.phase = CSSS_SW_INT_RUN;
                end
            end
            default: begin
                next_state.phase = CSSS_SW_INT_RUN;
                next_state.engaged = 1'b0;
                next_state.osc_run = 1'b1;
            end
        endcase

        // The pin level is taken unchanged as times-four once engaged.
        source_level = state.engaged ? state.pin_second : osc_link.clock_level;
        next_state.times_four = active ? source_level : 1'b0;
        if (next_state.times_four && !state.times_four) begin
            next_state.times_two = !state.times_two;
            if (!state.times_two) begin
                next_state.bus = !state.bus;
            end
        end

        // Pin ownership follows the selected source.
        next_state.amp = `CSSS_RESET_AMP;
        unique case (clock_source_select)
            CSSS_SRC_INTERNAL: begin
                next_state.input_select = state.engaged;
                next_state.pin_oe = clkout_pin_enable;
                next_state.pin_out = next_state.times_four;
                next_state.clkout_effective = clkout_pin_enable;
            end
            CSSS_SRC_DIRECT: begin
                next_state.input_select = 1'b1;
                next_state.pin_oe = 1'b0;
                next_state.pin_out = 1'b0;
                next_state.clkout_effective = 1'b0;
            end
            CSSS_SRC_RC: begin
                next_state.input_select = 1'b1;
                next_state.pin_oe = clkout_pin_enable;
                next_state.pin_out = next_state.times_four;
                next_state.clkout_effective = clkout_pin_enable;
            end
            CSSS_SRC_CRYSTAL: begin
                next_state.input_select = 1'b1;
                // The amplifier drives the inverse of the input pin.
                next_state.pin_oe = 1'b1;
                next_state.pin_out = !state.pin_second;
                next_state.clkout_effective = 1'b0;
                unique case (crystal_range_select)
                    CSSS_XTAL_8M_32M: next_state.amp = 3'h1;
                    CSSS_XTAL_1M_8M: next_state.amp = 3'h2;
                    CSSS_XTAL_32K_100K: next_state.amp = 3'h4;
                    CSSS_XTAL_RESERVED: next_state.amp = `CSSS_RESET_AMP;
                endcase
            end
        endcase
    end

    // Nothing here raises a request or keeps a break-sensitive flag.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state.pin_first <= `CSSS_RESET_LEVEL;
            state.pin_second <= `CSSS_RESET_LEVEL;
            state.pin_prev <= `CSSS_RESET_LEVEL;
            state.phase <= CSSS_SW_INT_RUN;
            state.edge_count <= 2'h0;
            state.osc_run <= 1'b1;
            state.engaged <= 1'b0;
            state.times_four <= `CSSS_RESET_LEVEL;
            state.times_two <= `CSSS_RESET_LEVEL;
            state.bus <= `CSSS_RESET_LEVEL;
            state.input_select <= 1'b0;
            state.amp <= `CSSS_RESET_AMP;
            state.pin_out <= 1'b0;
            state.pin_oe <= 1'b0;
            state.clkout_effective <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign bus_clock_times_four = state.times_four;
    assign bus_clock_times_two = state.times_two;
    assign bus_clock = state.bus;
    assign external_clock_engaged = state.engaged;
    assign internal_osc_enable = state.osc_run;
    assign clock_input_pin_select = state.input_select;
    assign crystal_amp_enable = state.amp;
    assign clock_output_pin_out = state.pin_out;
    assign clock_output_pin_oe = state.pin_oe;
    assign clkout_pin_enable_effective = state.clkout_effective;
endmodule

`default_nettype wire

// *** design/csss_regs.svh ***
// Constants of the clock source select and switch block.
// Assumes the including file defines nothing with the CSSS_ prefix.
`ifndef CSSS_REGS_SVH
`define CSSS_REGS_SVH

// System clock rate in kHz (125 MHz, 8 ns period).
`define CSSS_SYS_CLK_KHZ 125000
// Nominal internal oscillator rates in kHz for the three settings.
`define CSSS_INT_FREQ_LOW_KHZ 4000
`define CSSS_INT_FREQ_MID_KHZ 8000
`define CSSS_INT_FREQ_HIGH_KHZ 12800
// Width of the phase accumulator that models the internal oscillator.
`define CSSS_ACC_WIDTH 16
// One trim step scales the phase step by 2 to the minus this shift.
`define CSSS_TRIM_SHIFT 9
// Width of the trim value.
`define CSSS_TRIM_WIDTH 8
// Rising edges of the external clock that prove activity.
`define CSSS_ACTIVITY_EDGES 2
// Reset values.
`define CSSS_RESET_LEVEL 1'b0
`define CSSS_RESET_AMP 3'h0

`endif

// *** design/csss_pkg.sv ***
// Types shared by the clock source select and switch block.
// Assumes csss_regs.svh is on the include path.
package csss_pkg;

    // Clock source choice.
    typedef enum logic [1:0] {
        CSSS_SRC_INTERNAL = 2'b00,
        CSSS_SRC_DIRECT = 2'b01,
        CSSS_SRC_RC = 2'b10,
        CSSS_SRC_CRYSTAL = 2'b11
    } csss_source_type;

    // Internal oscillator rate choice.
    typedef enum logic [1:0] {
        CSSS_FREQ_4M0 = 2'b00,
        CSSS_FREQ_8M0 = 2'b01,
        CSSS_FREQ_12M8 = 2'b10,
        CSSS_FREQ_RESERVED = 2'b11
    } csss_freq_type;

    // Crystal amplifier range choice.
    typedef enum logic [1:0] {
        CSSS_XTAL_8M_32M = 2'b00,
        CSSS_XTAL_1M_8M = 2'b01,
        CSSS_XTAL_32K_100K = 2'b10,
        CSSS_XTAL_RESERVED = 2'b11
    } csss_xtal_range_type;

    // Source switch sequence.
    typedef enum logic [2:0] {
        CSSS_SW_INT_RUN = 3'b000,
        CSSS_SW_EXT_CHECK = 3'b001,
        CSSS_SW_EXT_HANDOVER = 3'b010,
        CSSS_SW_EXT_RUN = 3'b011,
        CSSS_SW_INT_HANDOVER = 3'b100
    } csss_switch_type;

endpackage

// *** design/csss_osc_if.sv ***
// Link between the switch control and the internal oscillator model.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none

interface csss_osc_if;
    logic run;
    csss_pkg::csss_freq_type freq_select;
    logic [7:0] trim;
    logic clock_level;

    modport ctrl (output run, output freq_select, output trim, input clock_level);
    modport osc (input run, input freq_select, input trim, output clock_level);
endinterface

`default_nettype wire

// *** design/csss_internal_osc.sv ***
// Digital model of the trimmable internal oscillator as a phase accumulator.
// Assumes the controller holds run low to freeze it in a stopped state.
`timescale 1ns/1ps
`default_nettype none
`include "csss_regs.svh"

module csss_internal_osc #(
    parameter int ACC_WIDTH = `CSSS_ACC_WIDTH
) (
    input wire logic sys_clk,
    input wire logic reset,
    csss_osc_if.osc link
);
    import csss_pkg::*;

    localparam int STEP_LOW = (`CSSS_INT_FREQ_LOW_KHZ * (1 << ACC_WIDTH)) / `CSSS_SYS_CLK_KHZ;
    localparam int STEP_MID = (`CSSS_INT_FREQ_MID_KHZ * (1 << ACC_WIDTH)) / `CSSS_SYS_CLK_KHZ;
    localparam int STEP_HIGH = (`CSSS_INT_FREQ_HIGH_KHZ * (1 << ACC_WIDTH)) / `CSSS_SYS_CLK_KHZ;
    localparam int PROD_WIDTH = ACC_WIDTH + `CSSS_TRIM_WIDTH + 1;

    if (ACC_WIDTH < 12 || ACC_WIDTH > 16) begin : g_bad_width
        $error("csss_internal_osc: ACC_WIDTH must lie between 12 and 16");
    end

    typedef struct packed {
        logic [ACC_WIDTH-1:0] phase;
        logic level;
    } csss_osc_state_type;

    csss_osc_state_type state;
    csss_osc_state_type next_state;
    logic signed [PROD_WIDTH-1:0] base_step;
    logic signed [PROD_WIDTH-1:0] trim_delta;
    logic signed [PROD_WIDTH-1:0] trimmed_step;

    always_comb begin
        next_state = state;
        unique case (link.freq_select)
            CSSS_FREQ_8M0: base_step = PROD_WIDTH'(STEP_MID);
            CSSS_FREQ_12M8: base_step = PROD_WIDTH'(STEP_HIGH);
            CSSS_FREQ_4M0, CSSS_FREQ_RESERVED: base_step = PROD_WIDTH'(STEP_LOW);
        endcase
        // A larger trim shrinks the phase step, so the period grows.
        trim_delta = PROD_WIDTH'((base_step * $signed(link.trim)) >>> `CSSS_TRIM_SHIFT);
        trimmed_step = base_step - trim_delta;
        if (link.run) begin
            next_state.phase = state.phase + trimmed_step[ACC_WIDTH-1:0];
            next_state.level = next_state.phase[ACC_WIDTH-1];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign link.clock_level = state.level;
endmodule

`default_nettype wire

// *** tb/csss_clock_switch_chk.sv ***
// Concurrent checks on the ports of the clock source select and switch block.
// Assumes it is bound to csss_clock_switch and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module csss_clock_switch_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire csss_pkg::csss_source_type clock_source_select,
    input wire csss_pkg::csss_xtal_range_type crystal_range_select,
    input wire logic external_clock_enable,
    input wire logic clkout_pin_enable,
    input wire logic run_in_stop_enable,
    input wire logic stop_mode,
    input wire logic clock_input_pin,
    input wire logic bus_clock_times_four,
    input wire logic bus_clock_times_two,
    input wire logic bus_clock,
    input wire logic external_clock_engaged,
    input wire logic internal_osc_enable,
    input wire logic clock_input_pin_select,
    input wire logic [2:0] crystal_amp_enable,
    input wire logic clock_output_pin_out,
    input wire logic clock_output_pin_oe,
    input wire logic clkout_pin_enable_effective
);
    import csss_pkg::*;
    logic x4_q, x4_qq, x2_q, x2_qq, pin_q, pin_qq, pin_qqq;
    logic [1:0] edges;

    // Pin edges pass two flops as in the design and counting starts no later, so this count is never behind.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {x4_q, x4_qq, x2_q, x2_qq, pin_q, pin_qq, pin_qqq} <= 7'h00;
            edges <= 2'h0;
        end else begin
            {x4_qq, x4_q, x2_qq, x2_q, pin_qqq, pin_qq, pin_q} <= {x4_q, bus_clock_times_four, x2_q,
                bus_clock_times_two, pin_qq, pin_q, clock_input_pin};
            if (!external_clock_enable) begin
                edges <= 2'h0;
            end else if (pin_qq && !pin_qqq && edges != 2'h3) begin
                edges <= edges + 2'h1;
            end
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_direct_pin_free: assert property (clock_source_select == CSSS_SRC_DIRECT
        |=> !clock_output_pin_oe && !clkout_pin_enable_effective) else $error("direct mode drove the pin");
    a_internal_clkout: assert property (clock_source_select == CSSS_SRC_INTERNAL
        |=> clock_output_pin_oe == $past(clkout_pin_enable)) else $error("internal clkout wrong");
    a_rc_clkout: assert property (clock_source_select == CSSS_SRC_RC
        |=> clkout_pin_enable_effective == $past(clkout_pin_enable)) else $error("rc clkout wrong");
    a_clkout_follows: assert property (clkout_pin_enable && (clock_source_select == CSSS_SRC_INTERNAL
        || clock_source_select == CSSS_SRC_RC) |=> clock_output_pin_out == bus_clock_times_four)
        else $error("clock output does not follow");
    a_crystal_pins: assert property (clock_source_select == CSSS_SRC_CRYSTAL
        |=> clock_output_pin_oe && !clkout_pin_enable_effective && clock_input_pin_select)
        else $error("crystal pins wrong");
    a_amp_select: assert property (clock_source_select == CSSS_SRC_CRYSTAL && crystal_range_select != 2'h3
        |=> crystal_amp_enable == 3'h1 << $past(crystal_range_select)) else $error("amplifier wrong");
    a_pin_release: assert property ((clock_source_select == CSSS_SRC_INTERNAL && !external_clock_engaged)[*3]
        |-> !clock_input_pin_select) else $error("input pin held");
    a_engage_order: assert property ($rose(external_clock_engaged)
        |-> internal_osc_enable ##1 !internal_osc_enable) else $error("switch order wrong");
    a_activity_proof: assert property ($rose(external_clock_engaged) |-> edges >= 2'h2)
        else $error("engaged without two edges");
    a_return_internal: assert property (clock_source_select == CSSS_SRC_INTERNAL && !external_clock_enable
        && external_clock_engaged && !stop_mode |=> internal_osc_enable) else $error("no return");
    a_stop_halts: assert property (stop_mode && !run_in_stop_enable |=> !internal_osc_enable)
        else $error("runs in stop");
    a_half_rate: assert property ($changed(bus_clock_times_two)
        |-> (bus_clock_times_four && !x4_q) || (x4_q && !x4_qq)) else $error("times two off");
    a_quarter_rate: assert property ($changed(bus_clock)
        |-> (bus_clock_times_two && !x2_q) || (x2_q && !x2_qq)) else $error("bus clock off");
endmodule

`default_nettype wire

// *** tb/csss_ext_source.sv ***
// External clock source model driving the oscillator input pin.
// Assumes the bench starts and stops it through run.
`timescale 1ns/1ps
`default_nettype none

module csss_ext_source #(
    parameter real HALF_NS = 43.0
) (
    input wire logic run,
    output logic pin
);
    // A stopped source leaves the pin low, as a quiet oscillator output would.
    initial begin
        pin = 1'b0;
        forever begin
            #(HALF_NS);
            pin = run ? ~pin : 1'b0;
        end
    end
endmodule

`default_nettype wire

// *** tb/csss_clock_switch_tb.sv ***
// Self-checking bench for the clock source select and switch block.
// Assumes the design, its package, interface and header are compiled first.
`timescale 1ns/1ps
`default_nettype none

module csss_clock_switch_tb;
    import csss_pkg::*;
    logic sys_clk, reset, external_clock_enable, clkout_pin_enable, run_in_stop_enable, stop_mode, src_run;
    logic clock_input_pin, bus_clock_times_four, bus_clock_times_two, bus_clock, external_clock_engaged;
    logic internal_osc_enable, clock_input_pin_select, clock_output_pin_out, clock_output_pin_oe;
    logic clkout_pin_enable_effective;
    logic [2:0] crystal_amp_enable;
    logic [7:0] internal_osc_trim;
    csss_source_type clock_source_select;
    csss_xtal_range_type crystal_range_select;
    csss_freq_type internal_freq_select;
    int mismatches, checks_done, c4, c2, c1;

    csss_clock_switch u_csss_clock_switch (.sys_clk, .reset, .clock_source_select, .crystal_range_select,
        .internal_freq_select, .external_clock_enable, .internal_osc_trim, .clkout_pin_enable,
        .run_in_stop_enable, .stop_mode, .clock_input_pin, .bus_clock_times_four, .bus_clock_times_two,
        .bus_clock, .external_clock_engaged, .internal_osc_enable, .clock_input_pin_select,
        .crystal_amp_enable, .clock_output_pin_out, .clock_output_pin_oe, .clkout_pin_enable_effective);
    csss_ext_source u_csss_ext_source (.run(src_run), .pin(clock_input_pin));

    always @(posedge bus_clock_times_four) c4++;
    always @(posedge bus_clock_times_two) c2++;
    always @(posedge bus_clock) c1++;

    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("Error at %0t ns: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic count_edges(input int n);
        c4 = 0;
        c2 = 0;
        c1 = 0;
        cycles(n);
    endtask

    task automatic wait_engaged(input logic lvl);
        for (int i = 0; i < 300 && external_clock_engaged !== lvl; i++) @(negedge sys_clk);
        if (external_clock_engaged !== lvl) begin
            mismatches++;
            $display("Error at %0t ns: got %h expected %h", $time, external_clock_engaged, lvl);
            give_verdict();
        end
    endtask

    task automatic t_reset();
        check({internal_osc_enable, external_clock_engaged, clock_input_pin_select, clock_output_pin_oe,
            clkout_pin_enable_effective, crystal_amp_enable}, 8'h80);
        count_edges(2000);
        check_range(c4, 62, 66);
    endtask

    task automatic t_freq();
        int exp4[4] = '{64, 128, 205, 64};
        for (int f = 0; f < 4; f++) begin
            internal_freq_select = csss_freq_type'(f);
            cycles(100);
            count_edges(2000);
            check_range(c4, exp4[f] - 3, exp4[f] + 3);
            check_range(c2 * 2, c4 - 2, c4 + 2);
            check_range(c1 * 4, c4 - 4, c4 + 4);
        end
        internal_freq_select = CSSS_FREQ_4M0;
    endtask

    task automatic t_trim();
        internal_osc_trim = 8'h7F;
        cycles(50);
        count_edges(2000);
        check_range(c4, 40, 58);
        internal_osc_trim = 8'h80;
        cycles(50);
        count_edges(2000);
        check_range(c4, 70, 90);
        internal_osc_trim = 8'h00;
    endtask

    task automatic t_pins();
        logic [7:0] exp;
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 8; k++) begin
                clock_source_select = csss_source_type'(s);
                clkout_pin_enable = k[2];
                crystal_range_select = csss_xtal_range_type'(k[1:0]);
                cycles(4);
                exp = {2'b00, s != 0, s == 3 || (s != 1 && k[2]), (s == 0 || s == 2) && k[2], 3'h0};
                exp[2:0] = (s == 3 && k[1:0] != 2'h3) ? 3'h1 << k[1:0] : 3'h0;
                check({2'b00, clock_input_pin_select, clock_output_pin_oe, clkout_pin_enable_effective,
                    crystal_amp_enable}, exp);
                if (s == 3) check({7'h00, clock_output_pin_out}, 8'h01);
            end
        end
    endtask

    task automatic t_switch();
        src_run = 1'b1;
        for (int s = 1; s < 4; s++) begin
            clock_source_select = csss_source_type'(s);
            crystal_range_select = CSSS_XTAL_1M_8M;
            cycles(40);
            external_clock_enable = 1'b1;
            wait_engaged(1'b1);
            cycles(2);
            check({7'h00, internal_osc_enable}, 8'h00);
            count_edges(430);
            check_range(c4, 37, 43);
            clock_source_select = CSSS_SRC_INTERNAL;
            external_clock_enable = 1'b0;
            wait_engaged(1'b0);
            cycles(2);
            check({7'h00, internal_osc_enable}, 8'h01);
            count_edges(2000);
            check_range(c4, 62, 66);
        end
        src_run = 1'b0;
    endtask

    task automatic t_abort();
        clock_source_select = CSSS_SRC_RC;
        external_clock_enable = 1'b1;
        cycles(150);
        check({7'h00, external_clock_engaged}, 8'h00);
        external_clock_enable = 1'b0;
        clock_source_select = CSSS_SRC_INTERNAL;
        cycles(5);
    endtask

    task automatic t_stop();
        stop_mode = 1'b1;
        cycles(3);
        check({7'h00, internal_osc_enable}, 8'h00);
        count_edges(300);
        check_range(c4, 0, 0);
        run_in_stop_enable = 1'b1;
        cycles(3);
        check({7'h00, internal_osc_enable}, 8'h01);
        count_edges(2000);
        check_range(c4, 62, 66);
        stop_mode = 1'b0;
        run_in_stop_enable = 1'b0;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        mismatches = 0;
        checks_done = 0;
        reset = 1'b1;
        src_run = 1'b0;
        clock_source_select = CSSS_SRC_INTERNAL;
        crystal_range_select = CSSS_XTAL_8M_32M;
        internal_freq_select = CSSS_FREQ_4M0;
        external_clock_enable = 1'b0;
        internal_osc_trim = 8'h00;
        clkout_pin_enable = 1'b0;
        run_in_stop_enable = 1'b0;
        stop_mode = 1'b0;
        repeat (4) @(negedge sys_clk);
        reset = 1'b0;
        cycles(2);
        t_reset();
        t_freq();
        t_trim();
        t_pins();
        t_switch();
        t_abort();
        t_stop();
        give_verdict();
    end
endmodule

bind csss_clock_switch csss_clock_switch_chk u_csss_clock_switch_chk (.sys_clk, .reset, .clock_source_select,
    .crystal_range_select, .external_clock_enable, .clkout_pin_enable, .run_in_stop_enable, .stop_mode,
    .clock_input_pin, .bus_clock_times_four, .bus_clock_times_two, .bus_clock, .external_clock_engaged,
    .internal_osc_enable, .clock_input_pin_select, .crystal_amp_enable, .clock_output_pin_out, .clock_output_pin_oe,
    .clkout_pin_enable_effective);

`default_nettype wire
